// *** wtr_core.sv ***
// watchdog, time base, rtc divider and halt/wake control
`timescale 1ns/1ps
`default_nettype none
`include "wtr_defs.svh"
module wtr_core import wtr_pkg::*; #(
    parameter int DIV_STAGES = 7,
    parameter int PRE_BITS = 8,
    parameter int PORT_W = 8,
    parameter int WAKE_CYC = `WTR_WAKE_CYC
) (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // axi4-lite write
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // axi4-lite read
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // oscillators and pins
    input wire logic wdosc_tick,
    input wire logic rtcosc_tick,
    input wire logic ext_rst_pin_n,
    input wire logic [PORT_W-1:0] porta,
    // interrupt controller side
    input wire logic ext_irq_new,
    input wire logic irq_master_en,
    input wire logic stack_full,
    input wire logic irq_ack_tb,
    input wire logic irq_ack_rtc,
    output logic irq_call,
    output logic [7:0] irq_vector,
    // resets, clocks and ticks out
    output logic chip_rst,
    output logic warm_rst,
    output logic sys_clk_run,
    output logic lcd_clk,
    output logic buzz_clk,
    output logic tb_tick,
    output logic rtc_tick,
    // halt status
    output logic halted,
    output logic resume,
    output logic resume_irq
);
    localparam int CW = DIV_STAGES + PRE_BITS;
    localparam int WAKE_LAST = WAKE_CYC - 1;
    localparam int WW = $clog2(WAKE_CYC);

    ////////////////////////////////////////////////////////////////////////
    // bus slave
    logic bvalid_r, rvalid_r, wr_en;
    logic [1:0] bresp_r, rresp_r;
    logic [31:0] rdata_r, rd_mux;
    logic rd_hit;
    logic [5:0] widx, ridx;
    wtr_opt_t opt_r;
    logic [5:0] rtc_control_r;
    logic etbi_r, erti_r, tbf_r, rtf_r;
    logic [PORT_W-1:0] wake_mask_r, porta_q;
    logic pdf_r, to_r;
    wtr_state_t st_r;
    logic [WW-1:0] wcnt_r;

    // write waits for address and data together, no skid storage needed
    assign wr_en = s_axi_awvalid & s_axi_wvalid & ~bvalid_r;
    assign s_axi_awready = wr_en;
    assign s_axi_wready = wr_en;
    assign s_axi_arready = ~rvalid_r;
    assign widx = s_axi_awaddr[7:2];
    assign ridx = s_axi_araddr[7:2];

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            bvalid_r <= 1'b0;
            bresp_r <= `WTR_RESP_OK;
        end
        else if (wr_en)
        begin
            bvalid_r <= 1'b1;
            bresp_r <= (widx == `WTR_IDX_OPT || widx == `WTR_IDX_STAT ||
                        widx == `WTR_IDX_CMD || widx == `WTR_IDX_WAKE ||
                        widx == `WTR_IDX_RTC_CONTROL || widx == `WTR_IDX_IRQ_CONTROL_SECOND)
                       ? `WTR_RESP_OK : `WTR_RESP_ERR;
        end
        else if (s_axi_bready)
            bvalid_r <= 1'b0;
    end

    always_comb
    begin
        rd_mux = 32'h0000_0000;
        rd_hit = 1'b1;
        case (ridx)
            `WTR_IDX_OPT: rd_mux[11:0] = opt_r;
            `WTR_IDX_STAT: rd_mux[3:0] = {st_r == ST_WAKE,
                                          st_r == ST_HALT, to_r, pdf_r};
            `WTR_IDX_CMD: rd_mux = 32'h0000_0000;
            `WTR_IDX_WAKE: rd_mux[PORT_W-1:0] = wake_mask_r;
            `WTR_IDX_RTC_CONTROL: rd_mux[5:0] = rtc_control_r;
            `WTR_IDX_IRQ_CONTROL_SECOND:
            begin
                rd_mux[`WTR_IC_ETBI] = etbi_r;
                rd_mux[`WTR_IC_ERTI] = erti_r;
                rd_mux[`WTR_IC_TBF] = tbf_r;
                rd_mux[`WTR_IC_RTF] = rtf_r;
            end
            default: rd_hit = 1'b0;
        endcase
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            rvalid_r <= 1'b0;
            rdata_r <= 32'h0000_0000;
            rresp_r <= `WTR_RESP_OK;
        end
        else if (s_axi_arvalid && !rvalid_r)
        begin
            rvalid_r <= 1'b1;
            rdata_r <= rd_mux;
            rresp_r <= rd_hit ? `WTR_RESP_OK : `WTR_RESP_ERR;
        end
        else if (s_axi_rready)
            rvalid_r <= 1'b0;
    end

    assign s_axi_bvalid = bvalid_r;
    assign s_axi_bresp = bresp_r;
    assign s_axi_rvalid = rvalid_r;
    assign s_axi_rdata = rdata_r;
    assign s_axi_rresp = rresp_r;

    ////////////////////////////////////////////////////////////////////////
    // command decode
    logic wr_lo, cmd_wr, cmd_clr, cmd_p1, cmd_p2, cmd_halt;
    logic p1_seen_r, p2_seen_r, pair_done, wd_clr_ev;
    assign wr_lo = wr_en & s_axi_wstrb[0];
    assign cmd_wr = wr_lo && widx == `WTR_IDX_CMD && st_r == ST_RUN;
    assign cmd_clr = cmd_wr & s_axi_wdata[`WTR_CMD_CLR];
    assign cmd_p1 = cmd_wr & s_axi_wdata[`WTR_CMD_PAIR1];
    assign cmd_p2 = cmd_wr & s_axi_wdata[`WTR_CMD_PAIR2];
    assign cmd_halt = cmd_wr & s_axi_wdata[`WTR_CMD_HALT];
    assign pair_done = (p1_seen_r | cmd_p1) & (p2_seen_r | cmd_p2);
    // the other scheme's command is ignored; disabled makes all no-ops
    assign wd_clr_ev = opt_r.wd_en & (opt_r.clr_dual ? pair_done
                                                      : cmd_clr); // R1 R7

    always_ff @(posedge aclk)
    begin
        if (!aresetn || !opt_r.clr_dual || wd_clr_ev || !ext_rst_pin_n)
        begin
            p1_seen_r <= 1'b0;
            p2_seen_r <= 1'b0;
        end
        else
        begin
            p1_seen_r <= p1_seen_r | cmd_p1; // R7
            p2_seen_r <= p2_seen_r | cmd_p2;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // shared timer
    logic [1:0] div4_r;
    logic instr_tick, fs_tick;
    logic [CW-1:0] cnt_r;
    logic [CW:0] ones_w;
    logic wd_stage_r, wd_ovf_ev, tb_ev, rtc_ev, soft_rst;

    // instruction clock is only a quarter of aclk and dies in halt
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            div4_r <= 2'h0;
        else if (st_r != ST_HALT)
            div4_r <= div4_r + 2'h1; // R3
    end
    assign instr_tick = (div4_r == 2'h3) && st_r != ST_HALT;

    always_comb
    begin
        case (opt_r.wd_src) // R1
            `WTR_SRC_INSTR: fs_tick = instr_tick;
            `WTR_SRC_RTC: fs_tick = rtcosc_tick;
            default: fs_tick = wdosc_tick;
        endcase
    end

    assign ones_w[0] = 1'b1;
    genvar k;
    generate
        for (k = 0; k < CW; k++)
        begin : g_ones
            assign ones_w[k+1] = ones_w[k] & cnt_r[k];
        end
    endgenerate

    assign soft_rst = !ext_rst_pin_n || chip_rst;

    always_ff @(posedge aclk)
    begin
        if (!aresetn || soft_rst)
            cnt_r <= '0;
        else if (fs_tick)
            cnt_r <= cnt_r + 1'b1; // R8
    end

    assign tb_ev = fs_tick & ones_w[`WTR_TB_BASE + int'(opt_r.tb_sel)]; // R10
    assign rtc_ev = fs_tick & ones_w[`WTR_RTC_BASE + int'(rtc_control_r[2:0])]; // R13
    // extra stage after the prescaler: clearing it alone gives 2^15..2^16
    assign wd_ovf_ev = opt_r.wd_en & fs_tick & ones_w[CW] & wd_stage_r; // R2

    always_ff @(posedge aclk)
    begin
        if (!aresetn || soft_rst || warm_rst)
            wd_stage_r <= 1'b0; // R6
        else if (wd_clr_ev || cmd_halt)
            wd_stage_r <= 1'b0; // R6 R17
        else if (opt_r.wd_en && fs_tick && ones_w[CW])
            wd_stage_r <= 1'b1; // R2
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            tb_tick <= 1'b0;
            rtc_tick <= 1'b0;
        end
        else
        begin
            tb_tick <= tb_ev; // R12
            rtc_tick <= rtc_ev; // R15
        end
    end

    // taps keep going in halt when the source is an oscillator
    wtr_tap #(.CW(CW), .BASE(`WTR_TAP_BASE)) u_lcd (
        .aclk(aclk),
        .aresetn(aresetn),
        .cnt(cnt_r),
        .sel(opt_r.lcd_sel),
        .tap(lcd_clk)
    ); // R9 R16
    wtr_tap #(.CW(CW), .BASE(`WTR_TAP_BASE)) u_buzz (
        .aclk(aclk),
        .aresetn(aresetn),
        .cnt(cnt_r),
        .sel(opt_r.buzz_sel),
        .tap(buzz_clk)
    ); // R9

    ////////////////////////////////////////////////////////////////////////
    // software registers
    logic ic_wr, tb_new, rtc_new;
    assign ic_wr = wr_lo && widx == `WTR_IDX_IRQ_CONTROL_SECOND;
    assign tb_new = tb_ev & ~tbf_r;
    assign rtc_new = rtc_ev & ~rtf_r;

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            opt_r <= `WTR_OPT_RST;
        else if (wr_en && widx == `WTR_IDX_OPT)
        begin
            if (s_axi_wstrb[0])
                opt_r[7:0] <= s_axi_wdata[7:0];
            if (s_axi_wstrb[1])
                opt_r[11:8] <= s_axi_wdata[11:8];
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            wake_mask_r <= '0;
        else if (wr_lo && widx == `WTR_IDX_WAKE)
            wake_mask_r <= s_axi_wdata[PORT_W-1:0];
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn || soft_rst)
            rtc_control_r <= `WTR_RTC_CONTROL_RST;
        else if (wr_lo && widx == `WTR_IDX_RTC_CONTROL)
            rtc_control_r <= s_axi_wdata[5:0]; // R13
    end

    // hardware set beats a software or acknowledge clear
    always_ff @(posedge aclk)
    begin
        if (!aresetn || soft_rst)
        begin
            etbi_r <= 1'b0;
            erti_r <= 1'b0;
            tbf_r <= 1'b0;
            rtf_r <= 1'b0;
        end
        else
        begin
            if (ic_wr)
            begin
                etbi_r <= s_axi_wdata[`WTR_IC_ETBI];
                erti_r <= s_axi_wdata[`WTR_IC_ERTI];
            end
            if (tb_ev)
                tbf_r <= 1'b1; // R11
            else if (ic_wr)
                tbf_r <= s_axi_wdata[`WTR_IC_TBF];
            else if (irq_ack_tb)
                tbf_r <= 1'b0;
            if (rtc_ev)
                rtf_r <= 1'b1; // R14
            else if (ic_wr)
                rtf_r <= s_axi_wdata[`WTR_IC_RTF];
            else if (irq_ack_rtc)
                rtf_r <= 1'b0;
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            irq_call <= 1'b0;
            irq_vector <= 8'h00;
        end
        else
        begin
            irq_call <= 1'b0;
            if (st_r == ST_RUN && irq_master_en && !stack_full)
            begin
                if (tbf_r && etbi_r)
                begin
                    irq_call <= 1'b1;
                    irq_vector <= `WTR_VEC_TB; // R11
                end
                else if (rtf_r && erti_r)
                begin
                    irq_call <= 1'b1;
                    irq_vector <= `WTR_VEC_RTC; // R14
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // halt and wake
    logic port_fall, irq_wake, wake_any, irq_go;
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            porta_q <= '1;
        else
            porta_q <= porta;
    end
    assign port_fall = |(wake_mask_r & porta_q & ~porta); // R19
    // only a request that rises during halt wakes
    assign irq_wake = tb_new | rtc_new | ext_irq_new; // R21
    assign wake_any = !ext_rst_pin_n | irq_wake | port_fall | wd_ovf_ev;
    assign irq_go = irq_master_en & ~stack_full & ((tb_new & etbi_r) |
                    (rtc_new & erti_r) | ext_irq_new); // R20

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            st_r <= ST_RUN;
            wcnt_r <= '0;
            resume <= 1'b0;
            resume_irq <= 1'b0;
        end
        else
        begin
            resume <= 1'b0;
            case (st_r)
                ST_RUN:
                    if (cmd_halt && !chip_rst)
                        st_r <= ST_HALT; // R16
                ST_HALT:
                    if (wake_any)
                    begin
                        st_r <= ST_WAKE; // R19
                        wcnt_r <= '0;
                        resume_irq <= irq_go & ext_rst_pin_n & ~wd_ovf_ev;
                    end
                ST_WAKE:
                    if (wcnt_r == WW'(WAKE_LAST))
                    begin
                        st_r <= ST_RUN; // R22
                        resume <= 1'b1;
                    end
                    else
                        wcnt_r <= wcnt_r + 1'b1; // R22
                default: st_r <= ST_RUN;
            endcase
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            chip_rst <= 1'b0;
            warm_rst <= 1'b0;
        end
        else
        begin
            chip_rst <= wd_ovf_ev && st_r != ST_HALT; // R4
            warm_rst <= wd_ovf_ev && st_r == ST_HALT; // R5
        end
    end

    // power-on clears both; the reset pin leaves them as they were
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            pdf_r <= 1'b0;
            to_r <= 1'b0;
        end
        else if (wd_ovf_ev)
            to_r <= 1'b1; // R4 R5
        else if (cmd_halt)
        begin
            pdf_r <= 1'b1; // R18
            to_r <= 1'b0;
        end
        else if (wd_clr_ev)
            pdf_r <= 1'b0; // R18
    end

    assign halted = st_r != ST_RUN;
    assign sys_clk_run = st_r != ST_HALT; // R16

    ////////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    logic [WW:0] wlen_r;
    always_ff @(posedge aclk)
    begin
        if (!aresetn || st_r != ST_WAKE)
            wlen_r <= '0;
        else
            wlen_r <= wlen_r + 1'b1;
    end
    int wake_full = WAKE_CYC;

    sequence halt_cmd_s;
        st_r == ST_RUN && cmd_halt && !wd_ovf_ev;
    endsequence
    sequence halt_entered_s;
        st_r == ST_HALT && pdf_r && !to_r;
    endsequence

    wake_delay_a: assert property ($rose(resume) |-> // R22
        int'(wlen_r) == wake_full && $past(st_r) == ST_WAKE)
        else $error("resume not after full wake delay");
    halt_flags_a: assert property (halt_cmd_s |=> halt_entered_s) // R18
        else $error("halt did not set flags");
    ovf_normal_a: assert property (wd_ovf_ev && st_r != ST_HALT |=> // R4
        chip_rst && to_r ##1 !chip_rst)
        else $error("normal overflow without chip reset");
    ovf_halt_a: assert property (wd_ovf_ev && st_r == ST_HALT |=> // R5
        warm_rst && !chip_rst && to_r && st_r == ST_WAKE)
        else $error("halt overflow without warm reset");
    disabled_noop_a: assert property (!opt_r.wd_en |=> // R1
        !wd_stage_r || $past(wd_stage_r))
        else $error("disabled watchdog advanced");
    single_clr_a: assert property (wd_clr_ev && !opt_r.clr_dual |=> // R7
        !wd_stage_r && !chip_rst [*2])
        else $error("single clear failed");
    dual_hold_a: assert property (opt_r.wd_en && opt_r.clr_dual && cmd_clr
        && !cmd_p1 && !cmd_p2 && wd_stage_r && !fs_tick && ext_rst_pin_n
        && !warm_rst && !cmd_halt |=> wd_stage_r) // R7
        else $error("single clear acted in dual mode");
    tbf_set_a: assert property (tb_ev && !soft_rst |=> tbf_r) // R11
        else $error("time base flag not set");
    rtf_set_a: assert property (rtc_ev && !soft_rst |=> rtf_r) // R14
        else $error("rtc flag not set");
    stale_wake_a: assert property (st_r == ST_HALT && ext_rst_pin_n && // R21
        !port_fall && !wd_ovf_ev && !ext_irq_new && !rtc_new && tbf_r
        |=> st_r == ST_HALT)
        else $error("pending request woke the device");
    instr_stop_a: assert property (st_r == ST_HALT && // R3
        opt_r.wd_src == `WTR_SRC_INSTR |-> !fs_tick)
        else $error("instruction clock ran in halt");
    tb_call_a: assert property (st_r == ST_RUN && irq_master_en && // R11
        !stack_full && tbf_r && etbi_r |=>
        irq_call && irq_vector == `WTR_VEC_TB)
        else $error("time base call missing");
endmodule : wtr_core
`default_nettype wire

// *** wtr_defs.svh ***
// register map, field positions and timing counts of the watchdog timer
// How it works
// [R1] watchdog source is wdog osc, instr clock or rtc osc; disabled means no-op
// [R2] watchdog expires after 2^15 to 2^16 source clocks
// [R3] with instr clock source, halt stops the watchdog count
// [R4] overflow in normal run gives chip reset and sets expiry flag
// [R5] overflow in halt gives warm reset and sets expiry flag
// [R6] count cleared by reset pin low, clear commands or halt
// [R7] option picks single clear or the two-command pair clear
// [R8] shared timer is 7-stage divider plus 8-bit prescaler
// [R9] lcd tap fS/2^2..2^9, buzzer tap fS/2^2..2^9, option chosen
// [R10] time base tick at fS/2^12..2^15, option chosen
// [R11] time base tick sets bit 5 flag; enabled calls vector 14H
// [R12] time base tick offered as clock for second timer
// [R13] rtc divisor in rtc_control bits 2..0, 2^8..2^15
// [R14] rtc tick sets bit 6 flag; enabled calls vector 18H
// [R15] rtc tick offered as clock for first timer
// [R16] halt stops system clock; wdog/rtc sources and lcd keep running
// [R17] halt clears watchdog, count restarts on wdog or rtc source
// [R18] halt sets powerdown flag, clears expiry; clear command clears powerdown
// [R19] wake on reset pin, interrupt, port A fall or watchdog overflow
// [R20] interrupt wake resumes next unless enabled and stack not full
// [R21] request already pending before halt cannot wake
// [R22] every wake waits 1024 system clocks before resuming
`ifndef WTR_DEFS_SVH
`define WTR_DEFS_SVH
// register indices; byte address is four times the index
`define WTR_IDX_OPT 6'h00
`define WTR_IDX_STAT 6'h01
`define WTR_IDX_CMD 6'h02
`define WTR_IDX_WAKE 6'h03
`define WTR_IDX_RTC_CONTROL 6'h09
`define WTR_IDX_IRQ_CONTROL_SECOND 6'h1E
// command bits
`define WTR_CMD_CLR 0
`define WTR_CMD_PAIR1 1
`define WTR_CMD_PAIR2 2
`define WTR_CMD_HALT 3
// irq_control_second bits
`define WTR_IC_ETBI 1
`define WTR_IC_ERTI 2
`define WTR_IC_TBF 5
`define WTR_IC_RTF 6
// watchdog source codes
`define WTR_SRC_WDOSC 2'h0
`define WTR_SRC_INSTR 2'h1
`define WTR_SRC_RTC 2'h2
// reset values and taps
`define WTR_RTC_CONTROL_RST 6'h07
`define WTR_OPT_RST 12'h001
`define WTR_TB_BASE 12
`define WTR_RTC_BASE 8
`define WTR_TAP_BASE 1
`define WTR_VEC_TB 8'h14
`define WTR_VEC_RTC 8'h18
`define WTR_WAKE_CYC 1024
`define WTR_RESP_OK 2'h0
`define WTR_RESP_ERR 2'h2
`endif

// *** wtr_pkg.sv ***
// types shared by the watchdog timer modules
package wtr_pkg;
    typedef struct packed {
        logic [2:0] buzz_sel;
        logic [2:0] lcd_sel;
        logic [1:0] tb_sel;
        logic clr_dual;
        logic [1:0] wd_src;
        logic wd_en;
    } wtr_opt_t;
    typedef enum logic [1:0] {ST_RUN, ST_HALT, ST_WAKE} wtr_state_t;
endpackage : wtr_pkg

// *** wtr_tap.sv ***
// frequency tap picked from the shared timer count
`timescale 1ns/1ps
`default_nettype none
module wtr_tap #(
    parameter int CW = 15,
    parameter int BASE = 1
) (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // count and selection
    input wire logic [CW-1:0] cnt,
    input wire logic [2:0] sel,
    // tap
    output logic tap
);
    logic tap_r;
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            tap_r <= 1'b0;
        else
            tap_r <= cnt[BASE + int'(sel)]; // R9
    end
    assign tap = tap_r;
endmodule : wtr_tap
`default_nettype wire

// *** tb_top.sv ***
// register-level testbench of the watchdog timer core
`timescale 1ns/1ps
`default_nettype none
`include "wtr_defs.svh"
module tb_top;
    import wtr_pkg::*;
    localparam int WAKE_N = 8;
    localparam int LIMIT = 95000;
    logic aclk = 0, aresetn = 0;
    logic [7:0] awaddr = 0, araddr = 0, porta = 8'hFF;
    logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
    logic [31:0] wdata = 0, rdata, rd;
    logic [1:0] bresp, rresp, rsp;
    logic awready, wready, bvalid, arready, rvalid;
    logic wdosc = 0, rtcosc = 0, ext_rst_n = 1, mst_en = 0, ack_rtc = 0;
    logic irq_call, chip_rst, warm_rst, sys_run, lcd_clk, buzz_clk;
    logic tb_tick, rtc_tick, halted, resume, resume_irq;
    logic [7:0] irq_vector;
    int n_mismatch = 0, compares = 0, cyc = 0, n_tb = 0, n_rtc = 0, n;
    int n_lcd = 0, n_buzz = 0;
    logic lcd_q = 0, buzz_q = 0;
    wtr_core #(.WAKE_CYC(WAKE_N)) i_wtr_core (.aclk(aclk),
        .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready), .wdosc_tick(wdosc),
        .rtcosc_tick(rtcosc), .ext_rst_pin_n(ext_rst_n), .porta(porta),
        .ext_irq_new(1'b0), .irq_master_en(mst_en), .stack_full(1'b0),
        .irq_ack_tb(1'b0), .irq_ack_rtc(ack_rtc), .irq_call(irq_call),
        .irq_vector(irq_vector), .chip_rst(chip_rst), .warm_rst(warm_rst),
        .sys_clk_run(sys_run), .lcd_clk(lcd_clk), .buzz_clk(buzz_clk),
        .tb_tick(tb_tick), .rtc_tick(rtc_tick), .halted(halted),
        .resume(resume), .resume_irq(resume_irq));
    initial
    begin
        forever #10 aclk = ~aclk;
    end
    ////////////////////////////////////////////////////////////////////
    task automatic test_done;
        $display("mismatches %0d compares %0d", n_mismatch, compares);
        if (n_mismatch == 0 && compares > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : test_done
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("wrong value at %0t: got %h expected %h", $time, got,
                exp);
        end
    endtask : chk
    // ready sampled at the negedge is what the next rising edge sees
    task automatic wr(input logic [5:0] idx, input logic [31:0] d);
        @(posedge aclk);
        awaddr <= {idx, 2'b00};
        wdata <= d;
        awvalid <= 1;
        wvalid <= 1;
        bready <= 1;
        do @(negedge aclk); while (!(awready && wready));
        @(posedge aclk);
        awvalid <= 0;
        wvalid <= 0;
        do @(negedge aclk); while (bvalid !== 1'b1);
        rsp = bresp;
        @(posedge aclk);
        bready <= 0;
    endtask : wr
    task automatic rdr(input logic [5:0] idx);
        @(posedge aclk);
        araddr <= {idx, 2'b00};
        arvalid <= 1;
        rready <= 1;
        do @(negedge aclk); while (!arready);
        @(posedge aclk);
        arvalid <= 0;
        do @(negedge aclk); while (rvalid !== 1'b1);
        rd = rdata;
        rsp = rresp;
        @(posedge aclk);
        rready <= 0;
    endtask : rdr
    ////////////////////////////////////////////////////////////////////
    always @(posedge aclk)
    begin
        cyc <= cyc + 1;
        if (tb_tick === 1'b1)
            n_tb <= n_tb + 1;
        if (rtc_tick === 1'b1)
            n_rtc <= n_rtc + 1;
        // taps idle low after reset, so the first rise is a real one
        lcd_q <= lcd_clk;
        buzz_q <= buzz_clk;
        if (lcd_clk === 1'b1 && lcd_q === 1'b0)
            n_lcd <= n_lcd + 1;
        if (buzz_clk === 1'b1 && buzz_q === 1'b0)
            n_buzz <= n_buzz + 1;
        if (cyc == LIMIT)
        begin
            n_mismatch++;
            test_done();
        end
    end
    initial
    begin
        repeat (6) @(posedge aclk);
        aresetn <= 1;
        rdr(`WTR_IDX_OPT); chk(rd, 32'h001);
        rdr(`WTR_IDX_RTC_CONTROL); chk(rd, 32'h07);
        rdr(`WTR_IDX_STAT); chk(rd, 32'h0);
        rdr(6'h10); chk({rd, 30'h0, rsp}, {32'h0, 32'h2});
        wr(`WTR_IDX_RTC_CONTROL, 32'h00);
        wr(`WTR_IDX_IRQ_CONTROL_SECOND, 32'h04);
        mst_en <= 1;
        // one source tick every other cycle
        repeat (4096)
        begin
            @(posedge aclk) wdosc <= 1;
            @(posedge aclk) wdosc <= 0;
        end
        repeat (3) @(posedge aclk);
        chk(n_rtc, 16);
        chk(n_tb, 1);
        chk(n_lcd, 1024);
        chk(n_buzz, 1024);
        @(negedge aclk); chk({irq_call, irq_vector}, {1'b1, 8'h18});
        rdr(`WTR_IDX_IRQ_CONTROL_SECOND); chk(rd, 32'h64);
        @(posedge aclk) ack_rtc <= 1;
        @(posedge aclk) ack_rtc <= 0;
        mst_en <= 0;
        rdr(`WTR_IDX_IRQ_CONTROL_SECOND); chk(rd, 32'h24);
        // halt, then wake from a port A falling edge
        wr(`WTR_IDX_WAKE, 32'h01);
        wr(`WTR_IDX_CMD, 32'h08);
        @(negedge aclk); chk({halted, sys_run}, 2'b10);
        rdr(`WTR_IDX_STAT); chk(rd[2:0], 3'b101);
        @(posedge aclk) porta <= 8'hFE;
        n = 0;
        do begin @(negedge aclk); n++; end while (!resume && n < 100);
        chk(n >= WAKE_N && n <= WAKE_N + 3, 1);
        chk(resume_irq, 1'b0);
        porta <= 8'hFF;
        wr(`WTR_IDX_CMD, 32'h01);
        rdr(`WTR_IDX_STAT); chk(rd, 32'h0);
        // free-running source until the watchdog fires
        @(posedge aclk) wdosc <= 1;
        n = 0;
        do begin @(negedge aclk); n++; end while (!chip_rst && n < 70000);
        @(posedge aclk) wdosc <= 0;
        chk(n >= 32768 && n <= 65538, 1);
        rdr(`WTR_IDX_STAT); chk(rd, 32'h2);
        rdr(`WTR_IDX_RTC_CONTROL); chk(rd, 32'h07);
        test_done();
    end
endmodule : tb_top
`default_nettype wire
